// [verilog/sba_map.svh]
// Offsets, field positions, reset values and timing counts of the serial bus unit.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
`ifndef SBA_MAP_SVH
`define SBA_MAP_SVH

`define SBA_OFS_OWN_HI      8'h00
`define SBA_OFS_OWN_LO      8'h04
`define SBA_OFS_TGT_LO      8'h08
`define SBA_OFS_TGT_HI      8'h0c
`define SBA_OFS_CTRL        8'h10
`define SBA_OFS_STAT        8'h14
`define SBA_OFS_REC         8'h18

`define SBA_RST_ADDR        8'h00
`define SBA_TGT_LO_MSB      7
`define SBA_TGT_LO_LSB      4
`define SBA_CTRL_START      0
`define SBA_CTRL_BCAST      1

`define SBA_CLK_MHZ         25
`define SBA_BIT_TIME_NS     2000
`define SBA_BIT_CYC         ((`SBA_BIT_TIME_NS * `SBA_CLK_MHZ) / 1000)

`define SBA_NBITS           29
`define SBA_IDX_MPAR        5'd14
`define SBA_IDX_SPAR        5'd27
`define SBA_IDX_ACK         5'd28
`define SBA_RX_BCASTN       26
`define SBA_RX_MADDR_MSB    25
`define SBA_RX_MADDR_LSB    14
`define SBA_RX_SADDR_MSB    12
`define SBA_RX_SADDR_LSB    1

`endif

// [verilog/sba_pkg.sv]
// Types shared by both ends of the serial bus arbitration link.
// Assumes nothing of its surroundings.
package sba_pkg;

    typedef enum logic [2:0] {
        SBA_IDLE = 3'b001,
        SBA_RUN  = 3'b010,
        SBA_DONE = 3'b100
    } sba_state_t;

    // Outcome of one frame header as seen by a unit.
    typedef struct packed {
        logic        won;
        logic        started;
        logic        bcast;
        logic        ack_ok;
        logic        addressed;
        logic [11:0] maddr;
    } sba_rec_t;

endpackage

// [verilog/sba_link_if.sv]
// Shared wired-AND bus line between the unit and a peer unit.
// Assumes a passive pull-up: the line is high unless some end drives it.
`timescale 1ns/100ps
interface sba_link_if;

    logic dev_o;
    logic dev_oe;
    logic peer_o;
    logic peer_oe;
    wire  line;

    assign line = (dev_oe ? dev_o : 1'b1) & (peer_oe ? peer_o : 1'b1);

    modport dev  (output dev_o, output dev_oe, input line);
    modport peer (output peer_o, output peer_oe, input line);

endinterface

// [verilog/sba_peer.sv]
// Peer unit on the shared line, driven from plain user-side ports.
// Assumes start is a one-cycle pulse and the addresses are stable during a frame.
`timescale 1ns/100ps
`include "sba_map.svh"
module sba_peer #(
    parameter int BIT_CYC = `SBA_BIT_CYC
) (
    // Clock and reset.
    input  wire logic            sys_clk,
    input  wire logic            reset,
    // User side.
    input  wire logic            start,
    input  wire logic            bcast,
    input  wire logic [11:0]     own_addr,
    input  wire logic [11:0]     tgt_addr,
    output sba_pkg::sba_rec_t    result,
    output logic                 result_valid,
    output logic                 busy,
    // Shared line.
    sba_link_if.peer             link
);
    import sba_pkg::*;

    sba_state_t          state_q;
    logic [15:0]         cnt_q;
    logic [4:0]          idx_q;
    logic [28:0]         frame_q;
    logic [28:0]         rx_q;
    logic                req_q;
    logic                tx_q;
    logic                ack_q;
    sba_rec_t            rec_q;

    wire        bit_end  = (cnt_q == 16'(BIT_CYC - 1));
    wire [28:0] rx_d     = {rx_q[27:0], link.line};
    wire [28:0] tx_frame = {1'b0, ~bcast, own_addr, ^own_addr, tgt_addr, ^tgt_addr, 1'b1};
    wire        mismatch = tx_q && (idx_q <= `SBA_IDX_MPAR) && (link.line != frame_q[28]);
    wire        hit      = (rx_d[`SBA_RX_SADDR_MSB:`SBA_RX_SADDR_LSB] == own_addr)
                           && !(^rx_d[`SBA_RX_SADDR_MSB:0]) && rx_d[`SBA_RX_BCASTN];

    assign link.peer_o  = 1'b0;
    assign link.peer_oe = (tx_q && !frame_q[28]) || ack_q;
    assign result       = rec_q;
    assign result_valid = (state_q == SBA_DONE);
    assign busy         = (state_q != SBA_IDLE) || req_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= SBA_IDLE;
            cnt_q   <= 16'h0000;
            idx_q   <= 5'h00;
            frame_q <= '0;
            rx_q    <= '0;
            req_q   <= 1'b0;
            tx_q    <= 1'b0;
            ack_q   <= 1'b0;
            rec_q   <= '0;
        end else begin
            case (state_q)
                SBA_IDLE: begin
                    idx_q <= 5'h00;
                    rx_q  <= '0;
                    // (RQ1) Pending request joins a started frame.
                    if ((req_q && link.line) || !link.line) begin
                        state_q <= SBA_RUN;
                        cnt_q   <= link.line ? 16'h0000 : 16'h0001;
                        tx_q    <= req_q;
                        frame_q <= tx_frame;
                        req_q   <= 1'b0;
                        rec_q   <= '0;
                        rec_q.started <= req_q;
                    end
                end
                SBA_RUN: begin
                    cnt_q <= bit_end ? 16'h0000 : cnt_q + 16'h0001;
                    if (bit_end) begin
                        rx_q    <= rx_d;
                        frame_q <= {frame_q[27:0], 1'b1};
                        idx_q   <= idx_q + 5'd1;
                        // (RQ5) Lower address wins the wired AND.
                        if (mismatch) begin
                            tx_q <= 1'b0;
                        end
                        // (RQ9) Addressed peer acknowledges normal frames.
                        if (idx_q == `SBA_IDX_SPAR) begin
                            ack_q <= !tx_q && hit;
                        end
                        if (idx_q == `SBA_IDX_ACK) begin
                            ack_q         <= 1'b0;
                            tx_q          <= 1'b0;
                            state_q       <= SBA_DONE;
                            rec_q.won     <= tx_q;
                            rec_q.bcast   <= !rx_q[`SBA_RX_BCASTN];
                            rec_q.ack_ok  <= !link.line || !rx_q[`SBA_RX_BCASTN];
                            rec_q.addressed <= ack_q;
                            rec_q.maddr   <= rx_q[`SBA_RX_MADDR_MSB:`SBA_RX_MADDR_LSB];
                        end
                    end
                end
                SBA_DONE: begin
                    state_q <= SBA_IDLE;
                end
                default: begin
                    state_q <= SBA_IDLE;
                end
            endcase
            // A new start pulse wins over the clear of a joining frame.
            if (start) begin
                req_q <= 1'b1;
            end
        end
    end

endmodule

// [verilog/sba_unit.sv]
// Frame-header unit of the wired-AND serial bus with an APB register file.
// Assumes APB is synchronous to sys_clk and the peer shares the line via sba_link_if.
// Behaviour
// (RQ1) Broadcast beats normal frames; arbitration resolves contention.
// (RQ2) Send 12-bit master address MSB first, parity.
// (RQ3) Same broadcast bit: master address decides.
// (RQ4) On bit mismatch stop sending, keep receiving.
// (RQ5) Smallest master address wins the wired AND.
// (RQ6) Survivor sends parity then slave address field.
// (RQ7) Even parity: one for odd ones count.
// (RQ8) Send 12-bit destination, parity, then ack slot.
// (RQ9) Normal frame: slave acknowledges, master checks it.
// (RQ10) Broadcast frame: master ignores the acknowledge.
// (RQ11) Own-address register gives upper 8 master bits.
// (RQ12) As slave compare own address with received.
// (RQ13) Target-low register holds 4 bits at 7:4.
// (RQ14) Target-low bits 3:0 read zero, ignore writes.
// (RQ15) Companion registers complete both 12-bit addresses.
// (RQ16) Address registers reset to zero; bit 7=address 11.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "sba_map.svh"
module sba_unit #(
    parameter int BIT_CYC = `SBA_BIT_CYC,
    parameter int DEPTH   = 2
) (
    // Clock and reset.
    input  wire logic            sys_clk,
    input  wire logic            reset,
    // APB slave.
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Shared line.
    sba_link_if.dev              link
);
    import sba_pkg::*;

    localparam int REC_W = $bits(sba_rec_t);

    // Registers.
    logic [7:0]          own_unit_address_high_q;
    logic [3:0]          own_addr_low_q;
    logic [3:0]          target_unit_address_low_q;
    logic [7:0]          target_addr_high_q;
    logic                bcast_q;
    logic                req_q;
    logic [31:0]         prdata_q;
    logic                err_q;

    // Frame engine.
    sba_state_t          state_q;
    logic [15:0]         cnt_q;
    logic [4:0]          idx_q;
    logic [28:0]         frame_q;
    logic [28:0]         rx_q;
    logic                tx_q;
    logic                ack_q;
    sba_rec_t            rec_q;

    // Event buffer.
    sba_rec_t            buf_mem [DEPTH];
    logic [1:0]          wr_ptr_q;
    logic [1:0]          rd_ptr_q;
    logic [2:0]          count_q;

    // Bus decode.
    wire        setup     = psel && !penable;
    wire        access    = psel && penable;
    wire        wr        = access && pwrite;
    wire        hit_ownhi = (paddr == `SBA_OFS_OWN_HI);
    wire        hit_ownlo = (paddr == `SBA_OFS_OWN_LO);
    wire        hit_tgtlo = (paddr == `SBA_OFS_TGT_LO);
    wire        hit_tgthi = (paddr == `SBA_OFS_TGT_HI);
    wire        hit_ctrl  = (paddr == `SBA_OFS_CTRL);
    wire        hit_stat  = (paddr == `SBA_OFS_STAT);
    wire        hit_rec   = (paddr == `SBA_OFS_REC);
    wire        hit_any   = hit_ownhi || hit_ownlo || hit_tgtlo || hit_tgthi
                            || hit_ctrl || hit_stat || hit_rec;

    // Buffer handshake.
    wire        in_valid  = (state_q == SBA_DONE);
    wire        in_ready  = (count_q < 3'(DEPTH));
    wire        out_valid = (count_q != 3'h0);
    wire        out_ready = access && !pwrite && hit_rec;
    wire        push      = in_valid && in_ready;
    wire        pop       = out_valid && out_ready;
    wire        full      = !in_ready;
    sba_rec_t   head;
    assign head = buf_mem[rd_ptr_q[0]];

    // (RQ11) Upper 8 bits come from the own-address register.
    // (RQ15) Companion registers complete the 12-bit fields.
    wire [11:0] own12     = {own_unit_address_high_q, own_addr_low_q};
    wire [11:0] tgt12     = {target_addr_high_q, target_unit_address_low_q};
    // (RQ2) Master address MSB first with parity.
    // (RQ7) Even parity over each 12-bit field.
    // (RQ8) Destination, parity, then the released ack slot.
    wire [28:0] tx_frame  = {1'b0, ~bcast_q, own12, ^own12, tgt12, ^tgt12, 1'b1};

    wire        bit_end   = (cnt_q == 16'(BIT_CYC - 1));
    wire [28:0] rx_d      = {rx_q[27:0], link.line};
    // (RQ4) Compare own bit with the line during arbitration.
    wire        mismatch  = tx_q && (idx_q <= `SBA_IDX_MPAR) && (link.line != frame_q[28]);
    // (RQ12) Slave compares the received destination with its own.
    wire        hit_slave = (rx_d[`SBA_RX_SADDR_MSB:`SBA_RX_SADDR_LSB] == own12)
                            && !(^rx_d[`SBA_RX_SADDR_MSB:0]) && rx_d[`SBA_RX_BCASTN];

    // Line drives low only; a one is the released line.
    assign link.dev_o  = 1'b0;
    assign link.dev_oe = (tx_q && !frame_q[28]) || ack_q;

    wire [31:0] rd_mux =
        hit_ownhi ? {24'h000000, own_unit_address_high_q} :
        hit_ownlo ? {28'h0000000, own_addr_low_q} :
        // (RQ14) Low nibble of the target-low register reads zero.
        hit_tgtlo ? {24'h000000, target_unit_address_low_q, 4'h0} :
        hit_tgthi ? {24'h000000, target_addr_high_q} :
        hit_ctrl  ? {30'h00000000, bcast_q, req_q} :
        hit_stat  ? {29'h00000000, full, req_q, state_q != SBA_IDLE} :
        hit_rec   ? {out_valid, 31'(head)} : 32'h00000000;

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = err_q && access;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prdata_q <= 32'h00000000;
            err_q    <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            err_q    <= !hit_any;
        end
    end

    // (RQ16) Address registers clear on reset.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            own_unit_address_high_q   <= `SBA_RST_ADDR;
            own_addr_low_q            <= 4'h0;
            target_unit_address_low_q <= 4'h0;
            target_addr_high_q        <= `SBA_RST_ADDR;
            bcast_q                   <= 1'b0;
        end else if (wr) begin
            if (hit_ownhi) begin
                own_unit_address_high_q <= pwdata[7:0];
            end
            if (hit_ownlo) begin
                own_addr_low_q <= pwdata[3:0];
            end
            // (RQ13) Only bits 7:4 are stored.
            if (hit_tgtlo) begin
                target_unit_address_low_q <= pwdata[`SBA_TGT_LO_MSB:`SBA_TGT_LO_LSB];
            end
            if (hit_tgthi) begin
                target_addr_high_q <= pwdata[7:0];
            end
            if (hit_ctrl) begin
                bcast_q <= pwdata[`SBA_CTRL_BCAST];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= 2'h0;
            rd_ptr_q <= 2'h0;
            count_q  <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 2'h1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 2'h1;
            end
            count_q <= count_q + {2'h0, push} - {2'h0, pop};
        end
    end

    // Buffer entries hold data only, so they carry no reset.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            buf_mem[wr_ptr_q[0]] <= rec_q;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= SBA_IDLE;
            cnt_q   <= 16'h0000;
            idx_q   <= 5'h00;
            frame_q <= '0;
            rx_q    <= '0;
            req_q   <= 1'b0;
            tx_q    <= 1'b0;
            ack_q   <= 1'b0;
            rec_q   <= '0;
        end else begin
            case (state_q)
                SBA_IDLE: begin
                    idx_q <= 5'h00;
                    rx_q  <= '0;
                    // (RQ1) A pending request joins a frame that starts now.
                    if ((req_q && link.line) || !link.line) begin
                        state_q <= SBA_RUN;
                        cnt_q   <= link.line ? 16'h0000 : 16'h0001;
                        tx_q    <= req_q;
                        frame_q <= tx_frame;
                        req_q   <= 1'b0;
                        rec_q   <= '0;
                        rec_q.started <= req_q;
                    end
                end
                SBA_RUN: begin
                    cnt_q <= bit_end ? 16'h0000 : cnt_q + 16'h0001;
                    if (bit_end) begin
                        rx_q    <= rx_d;
                        frame_q <= {frame_q[27:0], 1'b1};
                        idx_q   <= idx_q + 5'd1;
                        // (RQ3) Broadcast bit, then address bits, decide.
                        // (RQ5) A driven zero beats a released one.
                        if (mismatch) begin
                            tx_q <= 1'b0;
                        end
                        // (RQ9) Addressed slave drives the ack slot.
                        if (idx_q == `SBA_IDX_SPAR) begin
                            ack_q <= !tx_q && hit_slave;
                        end
                        // (RQ6) The survivor keeps sending into the slave field.
                        if (idx_q == `SBA_IDX_ACK) begin
                            ack_q           <= 1'b0;
                            tx_q            <= 1'b0;
                            state_q         <= SBA_DONE;
                            rec_q.won       <= tx_q;
                            rec_q.bcast     <= !rx_q[`SBA_RX_BCASTN];
                            // (RQ10) Broadcast passes without an acknowledge.
                            rec_q.ack_ok    <= !link.line || !rx_q[`SBA_RX_BCASTN];
                            rec_q.addressed <= ack_q;
                            rec_q.maddr     <= rx_q[`SBA_RX_MADDR_MSB:`SBA_RX_MADDR_LSB];
                        end
                    end
                end
                SBA_DONE: begin
                    // Waits here while the event buffer is full.
                    if (in_ready) begin
                        state_q <= SBA_IDLE;
                    end
                end
                default: begin
                    state_q <= SBA_IDLE;
                end
            endcase
            // A new start request wins over the clear of a joining frame.
            if (wr && hit_ctrl && pwdata[`SBA_CTRL_START]) begin
                req_q <= 1'b1;
            end
        end
    end

endmodule

// [tb/sba_link_props.sv]
// Checker of the shared wired-AND line between the unit and its peer.
// Assumes it watches the link interface signals and BIT_CYC matches both ends.
`timescale 1ns/100ps
module sba_link_props #(
    parameter int BIT_CYC = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Line and its drivers.
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic peer_o,
    input wire logic peer_oe,
    input wire logic line
);
    logic [31:0] cyc_q;
    logic        act_q;
    logic        bc_q;
    logic        lost_q;
    logic [11:0] sh_q;
    wire  [31:0] pos  = act_q ? cyc_q : 32'h0;
    wire  [31:0] bidx = pos / BIT_CYC;
    wire         smp  = act_q && (pos % BIT_CYC == BIT_CYC - 1);
    wire         adr  = (bidx >= 2 && bidx <= 13) || (bidx >= 15 && bidx <= 26);

    // Tracks the bit position from the first low level seen while the line is idle.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cyc_q <= 32'h0;
            act_q <= 1'h0;
            bc_q <= 1'h0;
            lost_q <= 1'h0;
            sh_q <= 12'h000;
        end else if (!act_q) begin
            act_q <= !line;
            cyc_q <= 32'h1;
            lost_q <= 1'h0;
        end else begin
            cyc_q <= cyc_q + 32'h1;
            act_q <= (cyc_q != 29 * BIT_CYC - 1);
            bc_q <= (smp && bidx == 1) ? !line : bc_q;
            sh_q <= (smp && adr) ? {sh_q[10:0], line} : sh_q;
            lost_q <= lost_q || (smp && bidx >= 1 && bidx <= 14 && !dev_oe && !line);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_OE_ALIGN: assert property ($changed(dev_oe) |-> pos % BIT_CYC == 0)
        else $error("unit drive changed inside a bit period");
    AST_START_LOW: assert property (act_q && bidx == 0 |-> !line)
        else $error("start bit not low for its whole period");
    AST_DRIVE_LOW: assert property (dev_oe |-> !dev_o)
        else $error("unit drives the line high");
    AST_WIRED_AND: assert property (line == ((dev_oe ? dev_o : 1'h1) & (peer_oe ? peer_o : 1'h1)))
        else $error("line is not the AND of its drivers");
    AST_LOST_QUIET: assert property (act_q && lost_q && bidx < 28 |-> !dev_oe)
        else $error("unit drives after losing arbitration");
    AST_MASTER_PARITY: assert property (smp && bidx == 14 |-> line == ^sh_q)
        else $error("master address parity not even");
    AST_SLAVE_PARITY: assert property (smp && bidx == 27 |-> line == ^sh_q)
        else $error("slave address parity not even");
    AST_BCAST_NO_ACK: assert property (act_q && bc_q && bidx == 28 |-> line)
        else $error("acknowledge driven in a broadcast frame");
    AST_RESET_QUIET: assert property ($fell(reset) |-> !dev_oe && !peer_oe)
        else $error("line driven right after reset");
endmodule

// [tb/tb.sv]
// Self-checking bench: unit and peer facing each other on the shared line.
// Assumes a short bit period via BIT_CYC and software access over APB.
`timescale 1ns/100ps
`include "sba_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module tb;
    import sba_pkg::*;
    localparam int BC = 4;
    logic        sys_clk  = 1'h0;
    logic        reset    = 1'h1;
    logic        psel     = 1'h0;
    logic        penable  = 1'h0;
    logic        pwrite   = 1'h0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic        start    = 1'h0;
    logic        bcast    = 1'h0;
    logic [11:0] own_addr = 12'h000;
    logic [11:0] tgt_addr = 12'h000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    sba_rec_t    result;
    logic        result_valid;
    logic        busy;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;

    sba_link_if i_sba_link_if ();
    sba_unit #(.BIT_CYC(BC), .DEPTH(2)) i_sba_unit (.sys_clk(sys_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(i_sba_link_if));
    sba_peer #(.BIT_CYC(BC)) i_sba_peer (.sys_clk(sys_clk), .reset(reset), .start(start),
        .bcast(bcast), .own_addr(own_addr), .tgt_addr(tgt_addr), .result(result),
        .result_valid(result_valid), .busy(busy), .link(i_sba_link_if));
    sba_link_props #(.BIT_CYC(BC)) i_sba_link_props (.sys_clk(sys_clk), .reset(reset),
        .dev_o(i_sba_link_if.dev_o), .dev_oe(i_sba_link_if.dev_oe),
        .peer_o(i_sba_link_if.peer_o), .peer_oe(i_sba_link_if.peer_oe),
        .line(i_sba_link_if.line));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'h1;
        // The request stands until the edge at which pready is seen high.
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] wd, ex);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, wd, r, e);
        apb(1'h0, a, 32'h0, r, e);
        `CHK("register", ex, r)
    endtask

    task automatic wait_peer();
        repeat (400) begin
            @(negedge sys_clk);
            if (result_valid === 1'h1) break;
        end
    endtask

    // Flags are unit start, unit broadcast, peer start, peer broadcast.
    task automatic run_case(input int k, input logic [11:0] dow, dtg, pow, ptg,
                            input logic [3:0] fl, input logic [16:0] dex, pex);
        logic [31:0] r;
        logic        e;
        apb(1'h1, `SBA_OFS_OWN_HI, {24'h0, dow[11:4]}, r, e);
        apb(1'h1, `SBA_OFS_OWN_LO, {28'h0, dow[3:0]}, r, e);
        apb(1'h1, `SBA_OFS_TGT_HI, {24'h0, dtg[11:4]}, r, e);
        apb(1'h1, `SBA_OFS_TGT_LO, {24'h0, dtg[3:0], 4'h0}, r, e);
        own_addr <= pow;
        tgt_addr <= ptg;
        bcast <= fl[0];
        if (fl[3]) apb(1'h1, `SBA_OFS_CTRL, {30'h0, fl[2], 1'h1}, r, e);
        if (fl[1]) begin
            start <= 1'h1;
            @(posedge sys_clk);
            start <= 1'h0;
        end
        wait_peer();
        `CHK("peer result", {1'h1, pex}, {result_valid, result})
        repeat (400) begin
            apb(1'h0, `SBA_OFS_STAT, 32'h0, r, e);
            if (r[1:0] === 2'h0 && busy === 1'h0) break;
        end
        apb(1'h0, `SBA_OFS_REC, 32'h0, r, e);
        `CHK("unit record", {1'h1, dex}, {r[31], r[16:0]})
        repeat (3) apb(1'h0, `SBA_OFS_REC, 32'h0, r, e);
        $display("test %0d finished", k);
    endtask

    initial begin
        logic [31:0] r;
        logic        e;
        logic [7:0]  ofs [4];
        ofs = '{`SBA_OFS_OWN_HI, `SBA_OFS_OWN_LO, `SBA_OFS_TGT_LO, `SBA_OFS_TGT_HI};
        repeat (12) @(posedge sys_clk);
        reset <= 1'h0;
        foreach (ofs[i]) begin
            apb(1'h0, ofs[i], 32'h0, r, e);
            `CHK("reset value", 32'h0, r)
        end
        apb(1'h1, 8'h40, 32'hffffffff, r, e);
        apb(1'h0, 8'h40, 32'h0, r, e);
        `CHK("unmapped access", {1'h1, 32'h0}, {e, r})
        chk_reg(`SBA_OFS_OWN_HI, 32'hffffffa5, 32'h000000a5);
        chk_reg(`SBA_OFS_TGT_LO, 32'hffffffff, 32'h000000f0);
        chk_reg(`SBA_OFS_TGT_LO, 32'h0000000a, 32'h00000000);
        $display("test registers finished");
        run_case(0, 12'h123, 12'h456, 12'h456, 12'h000, 4'h8, 17'h1a123, 17'h03123);
        run_case(1, 12'h123, 12'h456, 12'h0f0, 12'h123, 4'ha, 17'h0b0f0, 17'h1a0f0);
        run_case(2, 12'h123, 12'h456, 12'h0f0, 12'h123, 4'he, 17'h1e123, 17'h0e123);
        run_case(3, 12'habc, 12'h777, 12'h456, 12'h000, 4'h8, 17'h18abc, 17'h00abc);
        run_case(4, 12'h555, 12'h000, 12'h001, 12'h123, 4'h3, 17'h06001, 17'h1e001);
        repeat (3) begin
            start <= 1'h1;
            @(posedge sys_clk);
            start <= 1'h0;
            wait_peer();
            @(posedge sys_clk);
        end
        apb(1'h0, `SBA_OFS_STAT, 32'h0, r, e);
        `CHK("buffer full", 1'h1, r[2])
        // The third record waited in the unit and enters once a slot frees.
        repeat (3) begin
            apb(1'h0, `SBA_OFS_REC, 32'h0, r, e);
            `CHK("queued record", {1'h1, 17'h06001}, {r[31], r[16:0]})
        end
        apb(1'h0, `SBA_OFS_REC, 32'h0, r, e);
        `CHK("empty buffer", 1'h0, r[31])
        $display("test buffer finished");
        end_sim();
    end
endmodule
